// ==== gtc_pkg.sv ====
// Purpose: shared constants for the gated 16-bit timer/counter core
// Assumes: apb slave, 32-bit data, one word per register
// Notes: all offsets are byte addresses
`default_nettype none
package gtc_pkg;
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] GATE_OFF = 12'h004;
  localparam logic [11:0] CNTL_OFF = 12'h008;
  localparam logic [11:0] CNTH_OFF = 12'h00C;
  localparam logic [11:0] STAT_OFF = 12'h010;
  localparam logic [11:0] MASK_OFF = 12'h014;
  // counter_control_reg fields
  localparam int RUN_BIT = 0;
  localparam int SYNCDIS_BIT = 2;
  localparam int OSCEN_BIT = 3;
  localparam int PS_LSB = 4;
  localparam int CS_LSB = 6;
  // gate_control_reg fields, then the overflow bit of the status and mask registers
  localparam int GPOL_BIT = 6;
  localparam int GEN_BIT = 7;
  localparam int OVF_BIT = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] GATE_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_FOUR = 16'h0004;
  localparam logic [1:0] IC_DIV = 2'h3;
  localparam int SYNC_STAGES = 2;
  typedef enum logic [1:0] {SRC_INSTR, SRC_SYS, SRC_EXT, SRC_LFOSC} gtc_src_e;
endpackage : gtc_pkg
`default_nettype wire

// ==== gtc_sync.sv ====
// Purpose: two-stage synchroniser for one level
// Assumes: input is asynchronous to pclk
// Notes: first stage feeds only the second
`timescale 1ns/10ps
`default_nettype none
module gtc_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic s1;
    logic s2;
  } gtc_sync_s;
  gtc_sync_s st_q;
  gtc_sync_s st_d;
  always_comb
  begin
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_q <= '0;
    else
      st_q <= st_d;
  end
  assign dout = st_q.s2;
endmodule : gtc_sync
`default_nettype wire

// ==== gtc_prescale.sv ====
// Purpose: divide-by-1/2/4/8 prescaler on a tick stream
// Assumes: tick is a one-cycle pulse on pclk
// Notes: clear restarts the division
`timescale 1ns/10ps
`default_nettype none
module gtc_prescale (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  input wire logic [1:0] sel,
  input wire logic tick,
  output logic tick_out
);
  typedef struct packed {
    logic [2:0] cnt;
  } gtc_ps_s;
  gtc_ps_s st_q;
  gtc_ps_s st_d;
  logic [2:0] lim;
  always_comb
  begin
    lim = 3'((4'h1 << sel) - 4'h1);
    st_d = st_q;
    tick_out = 1'b0;
    if (clr)
      st_d.cnt = 3'h0;
    else if (tick)
    begin
      if (st_q.cnt >= lim)
      begin
        st_d.cnt = 3'h0;
        tick_out = 1'b1;
      end
      else
        st_d.cnt = 3'(st_q.cnt + 3'h1);
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_q <= '0;
    else
      st_q <= st_d;
  end
endmodule : gtc_prescale
`default_nettype wire

// ==== gtc_core.sv ====
// Purpose: gated 16-bit up timer/counter with apb registers
// Assumes: pclk is the system clock; osc and pin inputs are asynchronous
// Notes: asynchronous count mode is emulated by a single-stage sample of the count pin; the oscillator path stays two-stage
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module gtc_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_count_pin,
  input wire logic crystal_in_pin,
  output logic crystal_out_pin,
  input wire logic low_freq_internal_osc,
  input wire logic gate_pin,
  output logic irq
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] gctl;
    logic [15:0] cnt;
    logic ovf;
    logic mask;
    logic [1:0] phase;
    logic pin_d;
    logic osc_d;
    logic lf_d;
    logic raw_q;
    logic armed;
    logic en_d;
    logic int_out;
    logic [31:0] rdata;
  } gtc_core_s;
  gtc_core_s st_q;
  gtc_core_s st_d;

  logic pin_s;
  logic osc_s;
  logic lf_s;
  logic gate_s;
  logic ext_lvl;
  logic src_tick;
  logic ps_tick;
  logic ps_clr;
  logic run_en;
  logic wr;
  logic hit;
  gtc_pkg::gtc_src_e src;

  function automatic logic valid_addr(input logic [11:0] a);
    valid_addr = (a == gtc_pkg::CTRL_OFF) || (a == gtc_pkg::GATE_OFF)
      || (a == gtc_pkg::CNTL_OFF) || (a == gtc_pkg::CNTH_OFF)
      || (a == gtc_pkg::STAT_OFF) || (a == gtc_pkg::MASK_OFF);
  endfunction : valid_addr

  // crystal amplifier modelled as an inverter while enabled
  assign crystal_out_pin = st_q.ctrl[gtc_pkg::OSCEN_BIT] & ~crystal_in_pin;

  gtc_sync u_pin_sync (
    .pclk(pclk), .presetn(presetn), .din(ext_count_pin), .dout(pin_s)
  );
  gtc_sync u_osc_sync (
    .pclk(pclk), .presetn(presetn), .din(crystal_in_pin), .dout(osc_s)
  );
  gtc_sync u_lf_sync (
    .pclk(pclk), .presetn(presetn), .din(low_freq_internal_osc), .dout(lf_s)
  );
  gtc_sync u_gate_sync (
    .pclk(pclk), .presetn(presetn), .din(gate_pin), .dout(gate_s)
  );

  assign src = gtc_pkg::gtc_src_e'(st_q.ctrl[gtc_pkg::CS_LSB +: 2]);
  assign wr = psel & penable & pwrite;
  assign hit = valid_addr(paddr);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign ps_clr = wr & ((paddr == gtc_pkg::CNTL_OFF) | (paddr == gtc_pkg::CNTH_OFF));

  // unsynchronised mode takes a single sample only, trading metastability margin for latency
  assign ext_lvl = st_q.ctrl[gtc_pkg::SYNCDIS_BIT] ? st_q.raw_q : pin_s;

  always_comb
  begin
    run_en = st_q.ctrl[gtc_pkg::RUN_BIT];
    if (st_q.gctl[gtc_pkg::GEN_BIT])
      run_en = run_en & (gate_s == st_q.gctl[gtc_pkg::GPOL_BIT]);
  end

  always_comb
  begin
    src_tick = 1'b0;
    case (src)
      gtc_pkg::SRC_INSTR: src_tick = (st_q.phase == gtc_pkg::IC_DIV);
      gtc_pkg::SRC_SYS: src_tick = (st_q.phase == gtc_pkg::IC_DIV);
      gtc_pkg::SRC_LFOSC: src_tick = lf_s & ~st_q.lf_d;
      gtc_pkg::SRC_EXT:
      begin
        if (st_q.ctrl[gtc_pkg::OSCEN_BIT])
          src_tick = osc_s & ~st_q.osc_d;
        else
          src_tick = st_q.armed & ext_lvl & ~st_q.pin_d;
      end
      default: src_tick = 1'b0;
    endcase
  end

  gtc_prescale u_ps (
    .pclk(pclk),
    .presetn(presetn),
    .clr(ps_clr),
    .sel(st_q.ctrl[gtc_pkg::PS_LSB +: 2]),
    .tick(src_tick & run_en),
    .tick_out(ps_tick)
  );

  always_comb
  begin
    logic [15:0] step;
    logic [16:0] sum;
    step = gtc_pkg::CNT_ONE;
    sum = 17'h0_0000;
    st_d = st_q;
    st_d.phase = 2'(st_q.phase + 2'h1);
    st_d.raw_q = ext_count_pin;
    st_d.pin_d = ext_lvl;
    st_d.osc_d = osc_s;
    st_d.lf_d = lf_s;
    st_d.en_d = run_en;
    // a low level re-arms; enable, disable or a count write disarm
    if (!ext_lvl)
      st_d.armed = 1'b1;
    if ((run_en != st_q.en_d) || ps_clr)
      st_d.armed = 1'b0;
    if (src == gtc_pkg::SRC_SYS)
      step = gtc_pkg::CNT_FOUR;
    sum = {1'b0, st_q.cnt} + {1'b0, step};
    if (ps_tick)
    begin
      st_d.cnt = sum[15:0];
      if (sum[16])
        st_d.ovf = 1'b1;
    end
    if (wr)
    begin
      case (paddr)
        gtc_pkg::CTRL_OFF: st_d.ctrl = pwdata[7:0];
        gtc_pkg::GATE_OFF: st_d.gctl = pwdata[7:0];
        gtc_pkg::CNTL_OFF: st_d.cnt[7:0] = pwdata[7:0];
        gtc_pkg::CNTH_OFF: st_d.cnt[15:8] = pwdata[7:0];
        gtc_pkg::MASK_OFF: st_d.mask = pwdata[gtc_pkg::OVF_BIT];
        // write one to clear; a rollover in the same cycle still wins
        gtc_pkg::STAT_OFF:
          if (pwdata[gtc_pkg::OVF_BIT] && !(ps_tick && sum[16]))
            st_d.ovf = 1'b0;
        default: st_d.ctrl = st_q.ctrl;
      endcase
    end
    // read word is latched in the setup phase from the values that stand during the access phase
    st_d.rdata = 32'h0000_0000;
    if (psel && !penable && !pwrite)
    begin
      case (paddr)
        gtc_pkg::CTRL_OFF: st_d.rdata[7:0] = st_d.ctrl;
        gtc_pkg::GATE_OFF: st_d.rdata[7:0] = st_d.gctl;
        gtc_pkg::CNTL_OFF: st_d.rdata[7:0] = st_d.cnt[7:0];
        gtc_pkg::CNTH_OFF: st_d.rdata[7:0] = st_d.cnt[15:8];
        gtc_pkg::STAT_OFF: st_d.rdata[gtc_pkg::OVF_BIT] = st_d.ovf;
        gtc_pkg::MASK_OFF: st_d.rdata[gtc_pkg::OVF_BIT] = st_d.mask;
        default: st_d.rdata = 32'h0000_0000;
      endcase
    end
    st_d.int_out = st_d.ovf & st_d.mask;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= '0;
      st_q.ctrl <= gtc_pkg::CTRL_RST;
      st_q.gctl <= gtc_pkg::GATE_RST;
      st_q.cnt <= gtc_pkg::CNT_RST;
    end
    else
      st_q <= st_d;
  end

  // the read register is zero outside the access phase, so the bus stays quiet when idle
  assign prdata = st_q.rdata;
  assign irq = st_q.int_out;
endmodule : gtc_core
`default_nettype wire

// ==== gtc_ext_src.sv ====
// Purpose: far-side clock source for the pin and oscillator inputs
// Assumes: a free clock that runs only while en is high
// Notes: counts its own rising edges so the bench knows what was sent
`timescale 1ns/10ps
`default_nettype none
module gtc_ext_src #(
  parameter int HALF = 28
) (
  input wire logic en,
  output logic clk_out,
  output logic [7:0] rises
);
  // half period of 3.5 pclk periods, so a full period of 7; stands still low outside a burst
  initial
  begin
    clk_out = 1'h0;
    rises = 8'h00;
    forever
    begin
      #(HALF) clk_out = en & ~clk_out;
      if (!en)
        rises = 8'h00;
      else if (clk_out)
        rises = rises + 8'h01;
    end
  end
endmodule : gtc_ext_src
`default_nettype wire

// ==== gtc_core_sva.sv ====
// Purpose: port checks for the timer core
// Assumes: zero-wait apb
// Notes: run bit is mirrored from control writes
`timescale 1ns/10ps
`default_nettype none
module gtc_core_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic crystal_in_pin,
  input wire logic crystal_out_pin,
  input wire logic irq
);
  logic acc, rd, wr, run_q;
  assign acc = psel & penable;
  assign rd = acc & ~pwrite;
  assign wr = acc & pwrite;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      run_q <= 1'h0;
    else if (wr && paddr == gtc_pkg::CTRL_OFF)
      run_q <= pwdata[gtc_pkg::RUN_BIT];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_zero_wait_a: assert property (acc |-> pready)
    else $error("pready low in access");
  err_unmapped_a: assert property (acc && (paddr > 12'h014 || paddr[1:0] != 2'h0)
    |-> pslverr && prdata == 32'h0000_0000) else $error("unmapped access not refused");
  idle_quiet_a: assert property (!acc |-> !pslverr && prdata == 32'h0000_0000)
    else $error("bus outputs not quiet");
  read_upper_a: assert property (rd |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  cnt_write_a: assert property (rd && paddr == gtc_pkg::CNTL_OFF && !run_q
    && $past(wr && paddr == gtc_pkg::CNTL_OFF, 3) |-> prdata[7:0] == $past(pwdata[7:0], 3))
    else $error("count byte write lost");
  irq_mask_a: assert property (wr && paddr == gtc_pkg::MASK_OFF && !pwdata[0] |=> !irq)
    else $error("irq not masked");
  stat_irq_a: assert property (rd && paddr == gtc_pkg::STAT_OFF && irq |-> prdata[0])
    else $error("irq without flag");
  osc_out_a: assert property (crystal_in_pin |-> !crystal_out_pin)
    else $error("crystal drive wrong");
  cover property (wr && paddr == gtc_pkg::CNTL_OFF);
  cover property ($rose(irq));
  cover property (acc && pslverr);
endmodule : gtc_core_sva
bind gtc_core gtc_core_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .crystal_in_pin, .crystal_out_pin, .irq);
`default_nettype wire

// ==== gated_16bit_timer_counter_core_tb.sv ====
// Purpose: self-checking bench for the timer core
// Assumes: zero-wait apb; one source model feeds the routed input
// Notes: timed rows allow slack for the free-running cycle phase
`timescale 1ns/10ps
`default_nettype none
module gated_16bit_timer_counter_core_tb;
  typedef struct packed {
    logic [7:0] ctrl, gate;
    logic gpin;
    logic [1:0] route;
    logic [7:0] n, lo, hi;
  } gtc_row_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, gate_pin, e;
  logic crystal_out_pin, src_en, src_clk;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic [1:0] route;
  logic [7:0] src_rises;
  int bad_count, check_count;
  gtc_row_s r;
  gtc_row_s rows[12] = '{
    '{8'h81, 8'h00, 1'h0, 2'h1, 8'h05, 8'h05, 8'h05},
    '{8'h85, 8'h00, 1'h0, 2'h1, 8'h05, 8'h05, 8'h05},
    '{8'h89, 8'h00, 1'h0, 2'h2, 8'h05, 8'h05, 8'h05},
    '{8'hC1, 8'h00, 1'h0, 2'h3, 8'h05, 8'h05, 8'h05},
    '{8'hD1, 8'h00, 1'h0, 2'h3, 8'h08, 8'h04, 8'h04},
    '{8'hE1, 8'h00, 1'h0, 2'h3, 8'h08, 8'h02, 8'h02},
    '{8'hF1, 8'h00, 1'h0, 2'h3, 8'h10, 8'h02, 8'h02},
    '{8'h80, 8'h00, 1'h0, 2'h1, 8'h05, 8'h00, 8'h00},
    '{8'h01, 8'h00, 1'h0, 2'h0, 8'h28, 8'h0A, 8'h0B},
    '{8'h41, 8'h00, 1'h0, 2'h0, 8'h28, 8'h28, 8'h2C},
    '{8'h01, 8'hC0, 1'h0, 2'h0, 8'h28, 8'h00, 8'h00},
    '{8'h01, 8'hC0, 1'h1, 2'h0, 8'h28, 8'h0A, 8'h0B}};
  gtc_core DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ext_count_pin(src_clk & (route == 2'h1)),
    .crystal_in_pin(src_clk & (route == 2'h2)), .crystal_out_pin,
    .low_freq_internal_osc(src_clk & (route == 2'h3)), .gate_pin, .irq);
  gtc_ext_src SRC (.en(src_en), .clk_out(src_clk), .rises(src_rises));
  task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int i;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    for (i = 0; i < 16 && pready !== 1'h1; i++) @(posedge pclk);
    chk("ready", {15'h0000, pready}, 16'h0001);
    if (pready !== 1'h1) test_done();
    v = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb
  task automatic edges(input logic [7:0] n);
    int i;
    src_en <= 1'h1;
    for (i = 0; i < 2000 && src_rises !== n; i++) @(posedge pclk);
    chk("edges", {8'h00, src_rises}, {8'h00, n});
    if (src_rises !== n) test_done();
    src_en <= 1'h0;
    repeat (8) @(posedge pclk); // pin ticks still in the synchroniser
  endtask : edges
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done
  initial
  begin
    pclk = 1'h0;
    forever #4 pclk = ~pclk;
  end
  initial
  begin
    repeat (90000) @(posedge pclk);
    chk("timeout", 16'h0001, 16'h0000);
    test_done();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, gate_pin, src_en} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    route = 2'h0;
    bad_count = 0;
    check_count = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    foreach (rows[k])
    begin
      r = rows[k];
      apb(1'h1, gtc_pkg::CNTL_OFF, 8'h00);
      apb(1'h1, gtc_pkg::CNTH_OFF, 8'h00);
      apb(1'h1, gtc_pkg::GATE_OFF, r.gate);
      gate_pin <= r.gpin;
      route <= r.route;
      apb(1'h1, gtc_pkg::CTRL_OFF, r.ctrl);
      // source idle and low here, so an enabled crystal amplifier drives its output high
      if (r.ctrl[gtc_pkg::OSCEN_BIT])
        chk("xtal_drive", {15'h0000, crystal_out_pin}, 16'h0001);
      if (r.route != 2'h0)
        edges(r.n);
      else
        repeat (r.n) @(posedge pclk);
      apb(1'h1, gtc_pkg::CTRL_OFF, 8'h00);
      apb(1'h0, gtc_pkg::CNTL_OFF, 8'h00);
      chk("count", {15'h0000, v[7:0] >= r.lo && v[7:0] <= r.hi}, 16'h0001);
      if (r.ctrl[7:6] == 2'h1)
        chk("lsb", {14'h0000, v[1:0]}, 16'h0000);
      $display("row %0d done", k);
    end
    // high byte first, so the low read directly follows its own write
    apb(1'h1, gtc_pkg::CNTH_OFF, 8'h5A);
    apb(1'h1, gtc_pkg::CNTL_OFF, 8'hA5);
    apb(1'h0, gtc_pkg::CNTL_OFF, 8'h00);
    chk("cnt_lo", v[15:0], 16'h00A5);
    apb(1'h0, gtc_pkg::CNTH_OFF, 8'h00);
    chk("cnt_hi", v[15:0], 16'h005A);
    apb(1'h0, 12'h018, 8'h00);
    chk("unmapped", {e, v[14:0]}, 16'h8000);
    $display("bytes done");
    apb(1'h1, gtc_pkg::CNTH_OFF, 8'hFF);
    apb(1'h1, gtc_pkg::CNTL_OFF, 8'hFF);
    apb(1'h1, gtc_pkg::MASK_OFF, 8'h01);
    route <= 2'h1;
    apb(1'h1, gtc_pkg::CTRL_OFF, 8'h81);
    edges(8'h01);
    chk("irq", {15'h0000, irq}, 16'h0001);
    apb(1'h0, gtc_pkg::STAT_OFF, 8'h00);
    chk("flag", v[15:0], 16'h0001);
    apb(1'h0, gtc_pkg::CNTH_OFF, 8'h00);
    chk("wrap", v[15:0], 16'h0000);
    apb(1'h1, gtc_pkg::MASK_OFF, 8'h00);
    chk("masked", {15'h0000, irq}, 16'h0000);
    apb(1'h1, gtc_pkg::STAT_OFF, 8'h01);
    apb(1'h0, gtc_pkg::STAT_OFF, 8'h00);
    chk("cleared", v[15:0], 16'h0000);
    $display("overflow done");
    presetn <= 1'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    for (int a = 0; a < 6; a++)
    begin
      apb(1'h0, 12'(a * 4), 8'h00);
      chk("reset", v[15:0], 16'h0000);
    end
    $display("reset done");
    test_done();
  end
endmodule : gated_16bit_timer_counter_core_tb
`default_nettype wire
